//--- design/rcsi_shift8.sv
`timescale 1ns/1ns
`default_nettype none

module rcsi_shift8 #(
  parameter int W = 8
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic load_in,
  input wire logic [W-1:0] load_val_in,
  input wire logic shift_in,
  input wire logic ser_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] q;
  } rcsi_shift_s;

  rcsi_shift_s state_reg;
  rcsi_shift_s state_next;

  // ----------------------------------------
  // load has priority over shift, msb first
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    if (load_in) begin
      state_next.q = load_val_in;
    end else if (shift_in) begin
      state_next.q = {state_reg.q[W-2:0], ser_in};
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q_out = state_reg.q;

endmodule

`default_nettype wire

//--- design/rcsi_top.sv
// Summary of operation
// - A data byte write loads the transmit register and presets the burst counter to ones.
// - After the write, the write decode and counter flag gate the phase clock out.
// - The counter counts eight card clocks, then its flag drops and stops the clock.
// - Transmit bits shift on the card clock falling edge, starting after the first cycle.
// - Each card memory holds model, settling time and relay position table.
// - Card select is held low by software for the whole identification read.
// - Address clear is pulsed high once per identification read, zeroing the card counter.
// - Advance line low increments the card address and loads the card converter.
// - The first location read is one, because advance follows the clear.
// - Each relay byte burst also shifts one identification byte back in.
// - Advance and burst repeat once per byte until all locations are read.
// - Returning identification bits are assembled into a byte readable by software.
// - Identification reads at power-up and relay writes later share the card lines.
// - After shifting all cards, the latch pulse moves data to driver outputs.
// - The latch starts low from reset and is pulsed only when software asks.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module rcsi_top (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire rcsi_pkg::rcsi_apb_req_s apb_in,
  output rcsi_pkg::rcsi_apb_rsp_s apb_out,
  input wire logic ident_serial_in,
  output rcsi_pkg::rcsi_card_s card_out
);
  import rcsi_pkg::*;

  rcsi_state_s state_reg;
  rcsi_state_s state_next;

  logic [DATA_W-1:0] tx_q;
  logic [DATA_W-1:0] cnt_q;
  logic [DATA_W-1:0] rx_q;
  logic burst_count_flag;
  logic relay_write_decode;
  logic tick;
  logic rise_ev;
  logic fall_ev;
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic wr_tx_ok;
  logic [31:0] rd_mux;
  logic rd_err;

  // ----------------------------------------
  // bus phase clock and burst gating
  // ----------------------------------------
  assign burst_count_flag = cnt_q[DATA_W-1];
  assign relay_write_decode = (state_reg.bst != BST_IDLE);
  assign tick = (state_reg.div_cnt == ECLK_HALF_CYC - 5'h1);
  // gate opens only on a whole high phase, so no runt edge reaches the cards
  assign rise_ev = tick && !state_reg.eph && relay_write_decode && burst_count_flag;
  assign fall_ev = tick && state_reg.eph && state_reg.card_clk;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign setup_ph = apb_in.psel && !apb_in.penable;
  assign access_ph = apb_in.psel && apb_in.penable;
  assign wr_acc = access_ph && apb_in.pwrite && !state_reg.err;
  assign wr_tx_ok = wr_acc && (apb_in.paddr == OFS_TX_DATA);

  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    unique case (apb_in.paddr)
      OFS_TX_DATA: begin
        rd_mux[DATA_W-1:0] = state_reg.tx_last;
        rd_err = apb_in.pwrite && relay_write_decode;
      end
      OFS_RX_DATA: begin
        rd_mux[DATA_W-1:0] = rx_q;
      end
      OFS_CTRL: begin
        rd_mux[CTRL_SEL_LSB +: CARD_SLOTS] = state_reg.sel_n;
        rd_mux[CTRL_ADV_BIT] = state_reg.adv_n;
        rd_mux[CTRL_LATCH_BIT] = state_reg.latch;
      end
      OFS_STATUS: begin
        rd_mux[STAT_BUSY_BIT] = relay_write_decode;
        rd_mux[STAT_DECODE_BIT] = relay_write_decode;
        rd_mux[STAT_FLAG_BIT] = burst_count_flag;
      end
      OFS_ADDR_CLEAR: begin
        rd_mux = '0;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.id_sync = {state_reg.id_sync[0], ident_serial_in};
    if (tick) begin
      state_next.div_cnt = '0;
      state_next.eph = !state_reg.eph;
    end else begin
      state_next.div_cnt = state_reg.div_cnt + 5'h1;
    end
    if (rise_ev) begin
      state_next.card_clk = 1'b1;
    end else if (fall_ev) begin
      state_next.card_clk = 1'b0;
    end
    unique case (state_reg.bst)
      BST_IDLE: begin
        if (wr_tx_ok) begin
          state_next.bst = BST_ARMED;
        end
      end
      BST_ARMED: begin
        if (rise_ev) begin
          state_next.bst = BST_RUN;
        end
      end
      BST_RUN: begin
        if (!burst_count_flag) begin
          state_next.bst = BST_IDLE;
        end
      end
      default: begin
        state_next.bst = BST_IDLE;
      end
    endcase
    if (setup_ph) begin
      state_next.prdata = rd_mux;
      state_next.err = rd_err;
    end
    if (wr_tx_ok) begin
      state_next.tx_last = apb_in.pwdata[DATA_W-1:0];
    end
    if (wr_acc && apb_in.paddr == OFS_CTRL) begin
      state_next.sel_n = apb_in.pwdata[CTRL_SEL_LSB +: CARD_SLOTS];
      state_next.adv_n = apb_in.pwdata[CTRL_ADV_BIT];
      state_next.latch = apb_in.pwdata[CTRL_LATCH_BIT];
    end
    if (wr_acc && apb_in.paddr == OFS_ADDR_CLEAR && apb_in.pwdata[CLEAR_GO_BIT]) begin
      state_next.clr_cnt = CLR_PULSE_CYC;
    end else if (state_reg.clr_cnt != 7'h0) begin
      state_next.clr_cnt = state_reg.clr_cnt - 7'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_reg <= '0;
      state_reg.bst <= BST_IDLE;
      state_reg.sel_n <= SEL_N_RESET;
      state_reg.adv_n <= ADV_N_RESET;
      state_reg.latch <= LATCH_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // shift registers
  // ----------------------------------------
  rcsi_shift8 #(.W(DATA_W)) u_tx (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .load_in(wr_tx_ok),
    .load_val_in(apb_in.pwdata[DATA_W-1:0]),
    .shift_in(fall_ev),
    .ser_in(1'b0),
    .q_out(tx_q)
  );

  rcsi_shift8 #(.W(DATA_W)) u_count (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .load_in(wr_tx_ok),
    .load_val_in(COUNT_PRESET),
    .shift_in(fall_ev),
    .ser_in(1'b0),
    .q_out(cnt_q)
  );

  rcsi_shift8 #(.W(DATA_W)) u_rx (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .load_in(1'b0),
    .load_val_in('0),
    .shift_in(rise_ev),
    .ser_in(state_reg.id_sync[1]),
    .q_out(rx_q)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign apb_out.prdata = state_reg.prdata;
  assign apb_out.pready = access_ph;
  assign apb_out.pslverr = access_ph && state_reg.err;
  assign card_out.card_clk = state_reg.card_clk;
  assign card_out.relay_serial_out = tx_q[DATA_W-1];
  assign card_out.card_select_n = state_reg.sel_n;
  assign card_out.ident_addr_clear = (state_reg.clr_cnt != 7'h0);
  assign card_out.ident_addr_advance_n = state_reg.adv_n;
  assign card_out.latch = state_reg.latch;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [3:0] rise_cnt_reg;
  logic [3:0] rise_cnt_next;

  always_comb begin
    rise_cnt_next = rise_cnt_reg;
    if (wr_tx_ok) begin
      rise_cnt_next = 4'h0;
    end else if (rise_ev) begin
      rise_cnt_next = rise_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rise_cnt_reg <= 4'h0;
    end else begin
      rise_cnt_reg <= rise_cnt_next;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);

  sequence s_tx_write;
    wr_tx_ok;
  endsequence

  sequence s_burst_done;
    $fell(relay_write_decode);
  endsequence

  a_write_loads_byte: assert property (s_tx_write |=> tx_q == $past(apb_in.pwdata[7:0]) && burst_count_flag)
    else $error("byte write did not load transmit and counter");
  a_decode_follows: assert property (s_tx_write |=> relay_write_decode ##0 !card_out.card_clk)
    else $error("write decode not raised after write");
  a_clock_gated: assert property ($rose(card_out.card_clk)
    |-> $past(burst_count_flag) && $past(relay_write_decode))
    else $error("card clock without gate");
  a_eight_cycles: assert property (s_burst_done |-> rise_cnt_reg == 4'h8 && !burst_count_flag)
    else $error("burst did not hold eight clocks");
  a_shift_falls: assert property ($fell(card_out.card_clk) |-> card_out.relay_serial_out == $past(tx_q[6]))
    else $error("transmit did not shift on falling card clock");
  a_busy_refused: assert property (access_ph && apb_in.pwrite && apb_in.paddr == OFS_TX_DATA
    && relay_write_decode |-> (apb_out.pslverr && !wr_tx_ok) ##1 ($stable(tx_q) || $past(fall_ev)))
    else $error("write accepted during burst");
  a_clear_width: assert property ($rose(card_out.ident_addr_clear) |-> ##99 card_out.ident_addr_clear ##1
    !card_out.ident_addr_clear)
    else $error("address clear pulse width wrong");
  a_select_cause: assert property ($changed(card_out.card_select_n)
    |-> $past(wr_acc && apb_in.paddr == OFS_CTRL))
    else $error("card select changed without control write");
  a_rx_capture: assert property (rise_ev |=> rx_q[0] == $past(state_reg.id_sync[1]))
    else $error("receive bit not captured");

  // ----------------------------------------
  // burst timing and transmit data checks
  // ----------------------------------------
  sequence s_clk_high_end;
    card_out.card_clk ##1 !card_out.card_clk;
  endsequence

  sequence s_clk_low_end;
    !card_out.card_clk ##1 card_out.card_clk;
  endsequence

  sequence s_last_fall;
    $fell(card_out.card_clk) && !burst_count_flag;
  endsequence

  a_first_rise_bound: assert property (s_tx_write |-> ##[2:55] card_out.card_clk)
    else $error("first card clock not within one phase clock period");
  a_high_phase: assert property ($rose(card_out.card_clk) |-> ##26 s_clk_high_end)
    else $error("card clock high phase wrong length");
  a_low_phase: assert property ($fell(card_out.card_clk) && burst_count_flag |-> ##26 s_clk_low_end)
    else $error("card clock low phase wrong length");
  a_run_on_rise: assert property ($rose(card_out.card_clk) |-> state_reg.bst == BST_RUN)
    else $error("card clock rose outside running burst");
  a_decode_stays: assert property (relay_write_decode && burst_count_flag |=> relay_write_decode)
    else $error("write decode dropped while counter flag high");

  a_burst_stops: assert property (s_last_fall |=> !relay_write_decode)
    else $error("decode still high after eighth clock");
  a_idle_no_clock: assert property (!relay_write_decode |-> !card_out.card_clk)
    else $error("card clock outside burst");
  a_rise_limit: assert property (rise_ev |-> rise_cnt_reg < 4'h8)
    else $error("more than eight card clocks in one burst");
  a_count_holds: assert property (!fall_ev && !wr_tx_ok |=> $stable(cnt_q))
    else $error("burst counter moved without card clock");

  a_first_bit_out: assert property (s_tx_write |=> card_out.relay_serial_out == $past(apb_in.pwdata[7]))
    else $error("first serial bit not msb of byte");
  a_tx_holds: assert property (!fall_ev && !wr_tx_ok |=> $stable(tx_q))
    else $error("transmit register moved without falling card clock");
  a_tx_drained: assert property (s_last_fall |-> !card_out.relay_serial_out)
    else $error("transmit register not empty after burst");
  a_bit_hold: assert property ($rose(card_out.card_clk) |-> $stable(card_out.relay_serial_out))
    else $error("serial data moved on rising card clock");

  // ----------------------------------------
  // register and software cause checks
  // ----------------------------------------
  a_rx_holds: assert property (!rise_ev |=> $stable(rx_q))
    else $error("receive register moved without card clock");
  a_rx_readback: assert property (access_ph && !apb_in.pwrite && apb_in.paddr == OFS_RX_DATA
    |-> apb_out.prdata[DATA_W-1:0] == $past(rx_q))
    else $error("receive byte not returned on read");
  a_write_answered: assert property (s_tx_write |-> apb_out.pready && !apb_out.pslverr)
    else $error("accepted byte write not answered cleanly");
  a_clear_cause: assert property ($rose(card_out.ident_addr_clear)
    |-> $past(wr_acc && apb_in.paddr == OFS_ADDR_CLEAR && apb_in.pwdata[CLEAR_GO_BIT]))
    else $error("address clear raised without clear write");
  a_advance_cause: assert property ($changed(card_out.ident_addr_advance_n)
    |-> $past(wr_acc && apb_in.paddr == OFS_CTRL))
    else $error("address advance changed without control write");
  a_latch_cause: assert property ($changed(card_out.latch)
    |-> $past(wr_acc && apb_in.paddr == OFS_CTRL))
    else $error("latch changed without control write");
  a_reset_levels: assert property ($fell(srst_in) |-> !card_out.latch && card_out.ident_addr_advance_n
    && card_out.card_select_n == SEL_N_RESET && !card_out.card_clk && !card_out.ident_addr_clear)
    else $error("card lines not at rest after reset");

endmodule

`default_nettype wire

//--- pkg/rcsi_pkg.sv
package rcsi_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int CARD_SLOTS = 6;
  localparam int APB_AW = 8;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [APB_AW-1:0] OFS_TX_DATA = 8'h00;
  localparam logic [APB_AW-1:0] OFS_RX_DATA = 8'h04;
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h08;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_ADDR_CLEAR = 8'h10;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_ADV_BIT = 8;
  localparam int CTRL_LATCH_BIT = 9;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DECODE_BIT = 1;
  localparam int STAT_FLAG_BIT = 2;
  localparam int CLEAR_GO_BIT = 0;
  localparam logic [CARD_SLOTS-1:0] SEL_N_RESET = 6'h3f;
  localparam logic ADV_N_RESET = 1'h1;
  localparam logic LATCH_RESET = 1'h0;
  localparam logic [DATA_W-1:0] COUNT_PRESET = 8'hff;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ECLK_PERIOD_NS = 559;
  localparam logic [4:0] ECLK_HALF_CYC = 5'(ECLK_PERIOD_NS / 2 / CLK_PERIOD_NS);
  localparam int CLR_PULSE_NS = 1000;
  localparam logic [6:0] CLR_PULSE_CYC = 7'((CLR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    BST_IDLE = 2'h0,
    BST_ARMED = 2'h1,
    BST_RUN = 2'h3
  } rcsi_burst_e;

  typedef struct packed {
    logic [APB_AW-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } rcsi_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rcsi_apb_rsp_s;

  typedef struct packed {
    logic card_clk;
    logic relay_serial_out;
    logic [CARD_SLOTS-1:0] card_select_n;
    logic ident_addr_clear;
    logic ident_addr_advance_n;
    logic latch;
  } rcsi_card_s;

  typedef struct packed {
    rcsi_burst_e bst;
    logic [4:0] div_cnt;
    logic eph;
    logic card_clk;
    logic [1:0] id_sync;
    logic [DATA_W-1:0] tx_last;
    logic [CARD_SLOTS-1:0] sel_n;
    logic adv_n;
    logic latch;
    logic [6:0] clr_cnt;
    logic [31:0] prdata;
    logic err;
  } rcsi_state_s;

endpackage

//--- tb/rcsi_card_model.sv
`timescale 1ns/1ns
`default_nettype none

module rcsi_card_model #(
  parameter int SLOT = 0,
  parameter int HOLDOFF_NS = 200
) (
  input wire rcsi_pkg::rcsi_card_s card_in,
  output logic ident_serial_out,
  output logic [15:0] drv_out
);
  import rcsi_pkg::*;
  // ----------------------------------------
  // card state
  // ----------------------------------------
  logic [11:0] addr = 12'h000;
  logic [7:0] conv = 8'h00;
  logic [15:0] chain = 16'h0000;
  logic [15:0] held = 16'h0000;
  logic oe_n = 1'b1;
  wire logic sel = ~card_in.card_select_n[SLOT];

  function automatic logic [7:0] mem(input logic [11:0] a);
    return 8'hc0 + a[7:0];
  endfunction

  // ----------------------------------------
  // identification path and relay chain
  // ----------------------------------------
  always @(posedge card_in.ident_addr_clear) addr = 12'h000;
  always @(negedge card_in.ident_addr_advance_n) begin
    addr = addr + 12'h001;
    conv = mem(addr);
  end
  always @(posedge card_in.card_clk) begin
    conv = {conv[6:0], 1'b0};
    if (sel) begin
      chain = {chain[14:0], card_in.relay_serial_out};
    end
  end
  always @(posedge card_in.latch) held = chain;
  always @(negedge card_in.latch) begin
    if ($time > HOLDOFF_NS) begin
      oe_n = 1'b0;
    end
  end
  // undriven line shows the inverse of the last bit
  assign ident_serial_out = sel ? conv[7] : ~conv[7];
  assign drv_out = oe_n ? 16'hffff : ~held;
endmodule

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import rcsi_pkg::*;
  // ----------------------------------------
  // clock, design and card
  // ----------------------------------------
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  rcsi_apb_req_s req = '0;
  rcsi_apb_rsp_s rsp;
  rcsi_card_s card;
  wire logic ident;
  wire logic [15:0] drv;
  int n_fail = 0;
  int cmp_count = 0;
  int n_rise = 0;
  int clr_cyc = 0;
  int clr_pulses = 0;
  logic clk_q = 1'b0;
  logic clr_q = 1'b0;
  logic [31:0] rd;
  logic er;

  always #5 clock_in = ~clock_in;

  rcsi_top uut (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .apb_in(req),
    .apb_out(rsp),
    .ident_serial_in(ident),
    .card_out(card)
  );

  rcsi_card_model card0 (
    .card_in(card),
    .ident_serial_out(ident),
    .drv_out(drv)
  );

  always @(posedge clock_in) begin
    clk_q <= card.card_clk;
    clr_q <= card.ident_addr_clear;
    if (card.card_clk && !clk_q) n_rise <= n_rise + 1;
    if (card.ident_addr_clear) clr_cyc <= clr_cyc + 1;
    if (card.ident_addr_clear && !clr_q) clr_pulses <= clr_pulses + 1;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    req <= '{a, 1'b1, 1'b0, wr, d};
    @(posedge clock_in);
    req.penable <= 1'b1;
    do begin
      @(posedge clock_in);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 400);
    if (n >= 400) n_fail++;
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(card.card_select_n, 6'h3f);
    check(card.ident_addr_advance_n, 1'b1);
    check(card.latch, 1'b0);
    check(card.card_clk, 1'b0);
    check(drv, 16'hffff);
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h13f);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
  endtask

  task automatic t_relay();
    int n0;
    n0 = n_rise;
    apb(1'b1, OFS_CTRL, 32'h13e);
    apb(1'b1, OFS_TX_DATA, 32'ha5);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h7);
    check(card.relay_serial_out, 1'b1);
    apb(1'b1, OFS_TX_DATA, 32'hff);
    check(er, 1'b1);
    wait_idle();
    check(n_rise - n0, 8);
    repeat (100) @(posedge clock_in);
    check(n_rise - n0, 8);
    apb(1'b0, OFS_TX_DATA, 32'h0);
    check(rd, 32'ha5);
    apb(1'b1, OFS_TX_DATA, 32'h3c);
    wait_idle();
  endtask

  task automatic t_latch();
    apb(1'b1, OFS_CTRL, 32'h33e);
    check(drv, 16'hffff);
    apb(1'b1, OFS_CTRL, 32'h13e);
    @(posedge clock_in);
    check(drv, 16'h5ac3);
  endtask

  task automatic t_ident();
    apb(1'b1, OFS_ADDR_CLEAR, 32'h1);
    repeat (130) @(posedge clock_in);
    check(clr_cyc, 100);
    for (int loc = 1; loc <= 3; loc++) begin
      apb(1'b1, OFS_CTRL, 32'h03e);
      apb(1'b1, OFS_CTRL, 32'h13e);
      apb(1'b1, OFS_TX_DATA, 32'h5a);
      wait_idle();
      apb(1'b0, OFS_RX_DATA, 32'h0);
      check(rd, 32'hc0 + loc);
    end
    check(card.card_select_n, 6'h3e);
    check(clr_pulses, 1);
  endtask

  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    t_reset();
    t_relay();
    t_latch();
    t_ident();
    print_verdict();
  end
endmodule

`default_nettype wire
